/* File: ddr2_dev.sv */
// Purpose: Command decode, calibration, termination and posted column path
// Assumes: Every DRAM pin arrives from the link clock domain and is synchronised; col_ready_i is used unsynchronised
// Notes:   Link clock edges are found by sampling ck_i on clk_i
`timescale 1ns/10ps
module ddr2_dev (
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   input  wire logic                       ck_i,
   input  wire logic                       cs_n_i,
   input  wire logic                       ras_n_i,
   input  wire logic                       cas_n_i,
   input  wire logic                       we_n_i,
   input  wire logic [ddr2_pkg::BANK_W-1:0] ba_i,
   input  wire logic [ddr2_pkg::ROW_W-1:0] addr_i,
   input  wire logic                       odt_i,
   input  wire logic                       self_refresh_i,
   input  wire logic [ddr2_pkg::DQ_W-1:0]  dq_i,
   input  wire logic                       dqs_i,
   output logic      [ddr2_pkg::DQ_W-1:0]  dq_o,
   output logic                            dq_oe_o,
   output logic                            dqs_o,
   output logic                            dqs_n_o,
   output logic                            dqs_oe_o,
   output logic                            termination_switch_a_o,
   output logic                            termination_switch_b_o,
   output logic                            termination_switch_c_o,
   output logic      [3:0]                 pullup_step_o,
   output logic      [3:0]                 pulldown_step_o,
   output logic      [2:0]                 additive_latency_o,
   output logic      [3:0]                 read_latency_o,
   output logic      [3:0]                 write_latency_o,
   output logic                            act_valid_o,
   output logic      [ddr2_pkg::BANK_W-1:0] act_bank_o,
   output logic      [ddr2_pkg::ROW_W-1:0] act_row_o,
   output logic                            col_valid_o,
   input  wire logic                       col_ready_i,
   output ddr2_pkg::col_cmd_t              col_data_o,
   output logic                            cmd_lost_o
);
   import ddr2_pkg::*;

   // ************************************************************
   // Pin synchronisation and link clock edges
   // ************************************************************
   logic [SYNC_W-1:0] pins_s;
   logic              ck_s;
   logic              cs_n_s;
   logic              ras_n_s;
   logic              cas_n_s;
   logic              we_n_s;
   logic [BANK_W-1:0] ba_s;
   logic [ROW_W-1:0]  addr_s;
   logic              odt_s;
   logic              sr_s;
   logic [DQ_W-1:0]   dq_s;
   logic              dqs_s;
   logic              ck_q;
   logic              dqs_q;
   logic              ck_rise;
   logic              dqs_edge;

   sync2 #(.W(SYNC_W)) u_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    ({ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i,
                odt_i, self_refresh_i, dq_i, dqs_i}),
      .q_o    (pins_s)
   );

   assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s,
           odt_s, sr_s, dq_s, dqs_s} = pins_s;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ck_q  <= 1'b0;
         dqs_q <= 1'b0;
      end else begin
         ck_q  <= ck_s;
         dqs_q <= dqs_s;
      end
   end

   assign ck_rise  = ck_s & ~ck_q;
   assign dqs_edge = dqs_s ^ dqs_q;

   // ************************************************************
   // Command decode
   // ************************************************************
   logic is_mrs;
   logic is_act;
   logic is_col;
   logic emr1_wr;

   assign is_mrs  = ck_rise & ~cs_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
   assign is_act  = ck_rise & ~cs_n_s & ~ras_n_s & cas_n_s & we_n_s;
   assign is_col  = ck_rise & ~cs_n_s & ras_n_s & ~cas_n_s;
   assign emr1_wr = is_mrs & (ba_s == BA_EMR1);

   // ************************************************************
   // Mode register fields
   // ************************************************************
   logic [2:0] cl_q;
   logic [2:0] al_q;
   logic [1:0] rtt_q;
   logic [3:0] rl;
   logic [3:0] wl;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cl_q  <= CL_RESET;
         al_q  <= AL_RESET;
         rtt_q <= RTT_RESET;
      end else if (is_mrs) begin
         case (ba_s)
            BA_MR: begin
               cl_q <= addr_s[CL_LSB+:3];
            end
            BA_EMR1: begin
               al_q  <= (addr_s[AL_LSB+:3] > 3'(AL_MAX)) ? 3'(AL_MAX)
                                                        : addr_s[AL_LSB+:3];
               rtt_q <= {addr_s[RTT_HI], addr_s[RTT_LO]};
            end
            BA_EMR3: begin
               cl_q <= cl_q;
            end
            default: begin
               cl_q <= cl_q;
            end
         endcase
      end
   end

   assign rl                 = {1'b0, al_q} + {1'b0, cl_q};
   assign wl                 = rl - 4'h1;
   assign additive_latency_o = al_q;
   assign read_latency_o     = rl;
   assign write_latency_o    = wl;

   // ************************************************************
   // Driver calibration control
   // ************************************************************
   ocd_state_t state_q;
   logic [3:0] wait_q;
   logic [1:0] beat_q;
   logic [3:0] code_q;
   logic       adj_done_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q    <= OCD_IDLE;
         wait_q     <= 4'h0;
         beat_q     <= 2'h0;
         code_q     <= 4'h0;
         adj_done_q <= 1'b0;
      end else begin
         adj_done_q <= 1'b0;
         if (emr1_wr) begin
            case (addr_s[OCD_LSB+:3])
               OCD_EXIT:    state_q <= OCD_IDLE;
               OCD_DRV_HI:  state_q <= OCD_HI;
               OCD_DRV_LO:  state_q <= OCD_LO;
               OCD_DEFAULT: state_q <= OCD_IDLE;
               OCD_ADJUST: begin
                  state_q <= ADJ_WAIT;
                  wait_q  <= wl;
                  beat_q  <= 2'h0;
               end
               default:     state_q <= state_q;
            endcase
         end else begin
            case (state_q)
               ADJ_WAIT: begin
                  if (ck_rise) begin
                     if (wait_q <= 4'h1) begin
                        state_q <= ADJ_BEAT;
                     end else begin
                        wait_q <= wait_q - 4'h1;
                     end
                  end
               end
               ADJ_BEAT: begin
                  if (dqs_edge) begin
                     code_q[beat_q] <= dq_s[0];
                     beat_q         <= beat_q + 2'h1;
                     if (beat_q == 2'(ADJ_BEATS - 1)) begin
                        adj_done_q <= 1'b1;
                        state_q    <= OCD_IDLE;
                     end
                  end
               end
               default: state_q <= state_q;
            endcase
         end
      end
   end

   // ************************************************************
   // Driver strength steps
   // ************************************************************
   logic [3:0] pu_q;
   logic [3:0] pd_q;
   logic [3:0] adj_ops;

   function automatic logic [3:0] decode_code(input logic [3:0] t);
      case (t)
         4'b0001: decode_code = 4'b1000;
         4'b0010: decode_code = 4'b0100;
         4'b0100: decode_code = 4'b0010;
         4'b1000: decode_code = 4'b0001;
         4'b0101: decode_code = 4'b1010;
         4'b0110: decode_code = 4'b0110;
         4'b1001: decode_code = 4'b1001;
         4'b1010: decode_code = 4'b0101;
         default: decode_code = 4'b0000;
      endcase
   endfunction

   function automatic logic [3:0] step(input logic [3:0] s, input logic up,
                                       input logic dn);
      if (up && s != STEP_MAX) begin
         step = s + 4'h1;
      end else if (dn && s != 4'h0) begin
         step = s - 4'h1;
      end else begin
         step = s;
      end
   endfunction

   assign adj_ops = decode_code({code_q[0], code_q[1], code_q[2], code_q[3]});

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pu_q <= STEP_DEFAULT;
         pd_q <= STEP_DEFAULT;
      end else if (emr1_wr && addr_s[OCD_LSB+:3] == OCD_DEFAULT) begin
         pu_q <= STEP_DEFAULT;
         pd_q <= STEP_DEFAULT;
      end else if (adj_done_q) begin
         pu_q <= step(pu_q, adj_ops[3], adj_ops[2]);
         pd_q <= step(pd_q, adj_ops[1], adj_ops[0]);
      end
   end

   assign pullup_step_o   = pu_q;
   assign pulldown_step_o = pd_q;

   // ************************************************************
   // Drive mode outputs and termination
   // ************************************************************
   logic term_en;

   assign term_en = odt_s & ~sr_s;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dq_o     <= '0;
         dq_oe_o  <= 1'b0;
         dqs_o    <= 1'b0;
         dqs_n_o  <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else begin
         dq_o     <= {DQ_W{state_q == OCD_HI}};
         dq_oe_o  <= (state_q == OCD_HI) | (state_q == OCD_LO);
         dqs_o    <= (state_q == OCD_HI);
         dqs_n_o  <= (state_q == OCD_LO);
         dqs_oe_o <= (state_q == OCD_HI) | (state_q == OCD_LO);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         termination_switch_a_o <= 1'b0;
         termination_switch_b_o <= 1'b0;
         termination_switch_c_o <= 1'b0;
      end else begin
         termination_switch_a_o <= term_en & (rtt_q == RTT_75);
         termination_switch_b_o <= term_en & (rtt_q == RTT_150);
         termination_switch_c_o <= term_en & (rtt_q == RTT_50);
      end
   end

   // ************************************************************
   // Activate report
   // ************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         act_valid_o <= 1'b0;
         act_bank_o  <= '0;
         act_row_o   <= '0;
      end else begin
         act_valid_o <= is_act;
         if (is_act) begin
            act_bank_o <= ba_s;
            act_row_o  <= addr_s;
         end
      end
   end

   // ************************************************************
   // Posted column path
   // ************************************************************
   buf_if    post_if ();
   buf_if    out_if ();
   col_cmd_t slot_q [AL_MAX+1];
   logic [AL_MAX:0] slot_v_q;
   logic     stall;
   col_cmd_t new_cmd;

   assign new_cmd = '{write: ~we_n_s, bank: ba_s, col: addr_s};
   assign stall   = slot_v_q[0] & ~post_if.ready;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slot_v_q <= '0;
         for (int i = 0; i <= AL_MAX; i++) begin
            slot_q[i] <= '0;
         end
      end else if (ck_rise && !stall) begin
         for (int i = 0; i < AL_MAX; i++) begin
            slot_q[i]   <= slot_q[i+1];
            slot_v_q[i] <= slot_v_q[i+1];
         end
         slot_v_q[AL_MAX] <= 1'b0;
         if (is_col) begin
            slot_q[al_q]   <= new_cmd;
            slot_v_q[al_q] <= 1'b1;
         end
      end else if (slot_v_q[0] && post_if.ready) begin
         slot_v_q[0] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd_lost_o <= 1'b0;
      end else begin
         cmd_lost_o <= is_col & stall;
      end
   end

   assign post_if.valid = slot_v_q[0];
   assign post_if.data  = slot_q[0];
   assign out_if.ready  = col_ready_i;
   assign col_valid_o   = out_if.valid;
   assign col_data_o    = out_if.data;

   fifo2 u_buf (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .in_if  (post_if),
      .out_if (out_if)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence adj_cmd_s;
      emr1_wr && addr_s[OCD_LSB+:3] == OCD_ADJUST;
   endsequence

   act_decode_a: assert property (is_act |=> act_valid_o && act_bank_o == $past(ba_s))
      else $error("activate not reported");
   col_zero_al_a: assert property (is_col && !stall && al_q == 3'h0 |=> slot_v_q[0])
      else $error("column command not posted");
   col_hold_a: assert property (is_col && !stall && al_q == 3'h2 |=> slot_v_q[2])
      else $error("column command at wrong latency slot");
   al_load_a: assert property (emr1_wr && addr_s[AL_LSB+:3] <= 3'(AL_MAX)
      |=> additive_latency_o == $past(addr_s[AL_LSB+:3]))
      else $error("additive latency not loaded");
   ocd_exit_a: assert property (emr1_wr && addr_s[OCD_LSB+:3] == OCD_EXIT
      |=> state_q == OCD_IDLE)
      else $error("calibration exit ignored");
   drive_hi_a: assert property (state_q == OCD_HI ##1 state_q == OCD_HI
      |-> dq_oe_o && dq_o == {DQ_W{1'b1}} && dqs_o && !dqs_n_o)
      else $error("drive high levels wrong");
   adj_wait_a: assert property (adj_cmd_s |=> state_q == ADJ_WAIT && wait_q == $past(wl))
      else $error("adjust wait not armed");
   step_sat_a: assert property (adj_done_q && adj_ops[3] && pu_q == STEP_MAX
      |=> pu_q == STEP_MAX)
      else $error("pull-up step wrapped");
   self_ref_a: assert property (sr_s |=> !termination_switch_a_o
      && !termination_switch_b_o && !termination_switch_c_o)
      else $error("termination on in self refresh");
   rtt_sel_a: assert property (term_en && rtt_q == RTT_50
      |=> termination_switch_c_o && !termination_switch_a_o)
      else $error("termination leg wrong");
endmodule

/* File: ddr2_pkg.sv */
// Purpose: Shared constants and types for the DDR2 command-side device model
// Assumes: 250 MHz core clock samples every DRAM pin through two flip-flops
// Notes:   Widths are fixed at the device values
package ddr2_pkg;

   // ************************************************************
   // Timing and widths
   // ************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int AL_MAX        = 4;
   localparam int DQ_W          = 16;
   localparam int ROW_W         = 13;
   localparam int BANK_W        = 3;
   localparam int SYNC_W        = 40;

   // ************************************************************
   // Mode register selects on BA2..BA0
   // ************************************************************
   localparam logic [2:0] BA_MR   = 3'h0;
   localparam logic [2:0] BA_EMR1 = 3'h1;
   localparam logic [2:0] BA_EMR2 = 3'h2;
   localparam logic [2:0] BA_EMR3 = 3'h3;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CL_LSB  = 4;
   localparam int AL_LSB  = 3;
   localparam int OCD_LSB = 7;
   localparam int RTT_HI  = 6;
   localparam int RTT_LO  = 2;

   // ************************************************************
   // Calibration field codes and termination selects
   // ************************************************************
   localparam logic [2:0] OCD_EXIT    = 3'h0;
   localparam logic [2:0] OCD_DRV_HI  = 3'h1;
   localparam logic [2:0] OCD_DRV_LO  = 3'h2;
   localparam logic [2:0] OCD_ADJUST  = 3'h4;
   localparam logic [2:0] OCD_DEFAULT = 3'h7;
   localparam logic [1:0] RTT_75      = 2'h1;
   localparam logic [1:0] RTT_150     = 2'h2;
   localparam logic [1:0] RTT_50      = 2'h3;

   // ************************************************************
   // Reset values, step limit and adjust beat count
   // ************************************************************
   localparam logic [3:0] STEP_DEFAULT = 4'h8;
   localparam logic [3:0] STEP_MAX     = 4'hf;
   localparam logic [2:0] CL_RESET     = 3'h3;
   localparam logic [2:0] AL_RESET     = 3'h0;
   localparam logic [1:0] RTT_RESET    = 2'h0;
   localparam int         ADJ_BEATS    = 4;

   typedef struct packed {
      logic              write;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  col;
   } col_cmd_t;

   typedef enum logic [2:0] {
      OCD_IDLE = 3'b000,
      OCD_HI   = 3'b001,
      OCD_LO   = 3'b010,
      ADJ_WAIT = 3'b011,
      ADJ_BEAT = 3'b100
   } ocd_state_t;

endpackage

/* File: buf_if.sv */
// Purpose: Valid/ready carrier for posted column commands
// Assumes: Single clock domain
// Notes:   Word moves when valid and ready are both high
`timescale 1ns/10ps
interface buf_if;
   import ddr2_pkg::*;
   col_cmd_t data;
   logic     valid;
   logic     ready;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

/* File: sync2.sv */
// Purpose: Two-stage synchroniser for a vector of pins
// Assumes: Bits are sampled independently
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

/* File: fifo2.sv */
// Purpose: Two-entry buffer between the posting pipeline and the receiver
// Assumes: Receiver may hold ready low for any time
// Notes:   Ready on the filling side is low only when both entries hold data
`timescale 1ns/10ps
module fifo2 (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   buf_if.sink       in_if,
   buf_if.source     out_if
);
   import ddr2_pkg::*;

   col_cmd_t   mem_q [2];
   logic       rd_q;
   logic       wr_q;
   logic [1:0] cnt_q;
   logic       push;
   logic       pop;

   assign in_if.ready  = (cnt_q != 2'h2);
   assign out_if.valid = (cnt_q != 2'h0);
   assign out_if.data  = mem_q[rd_q];
   assign push         = in_if.valid & in_if.ready;
   assign pop          = out_if.valid & out_if.ready;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else if (push) begin
         mem_q[wr_q] <= in_if.data;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   word_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      out_if.valid && !out_if.ready |=> out_if.valid && $stable(out_if.data))
      else $error("buffered word changed before taken");
endmodule

/* File: ctrl_model.sv */
// Purpose: Controller model for commands and adjust bursts
// Assumes: Pins move 1 ns after clk_i
// Notes:   Link clock runs free at 32 ns
`timescale 1ns/10ps
module ctrl_model (
   input  wire logic        clk_i,
   output logic             ck_o,
   output logic [19:0]      pin_o,
   output logic [16:0]      dat_o
);
   initial begin
      {ck_o, pin_o, dat_o} = {1'b0, 4'hf, 33'h0};
      #3;
      forever #16 ck_o = ~ck_o;
   end
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
      @(negedge ck_o);
      @(posedge clk_i);
      #1 pin_o = {c, b, a};
      @(negedge ck_o);
      @(posedge clk_i);
      #1 pin_o = {4'hf, b, ~a};
   endtask
   task automatic adj(input logic [0:3] t, input int wl);
      cmd(4'h0, 3'h1, 13'h210);
      repeat (wl) @(posedge ck_o);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) #1 dat_o[16:1] = {16{t[i]}};
         repeat (3) @(posedge clk_i);
         #1 dat_o[0] = ~dat_o[0];
      end
      repeat (4) @(posedge clk_i);
      #1 dat_o[16:1] = ~dat_o[16:1];
      cmd(4'h0, 3'h1, 13'h010);
   endtask
endmodule

/* File: tb_ddr2_dev.sv */
// Purpose: Self-checking bench for the command-side device block
// Assumes: CL 3 and AL 2 after set-up, so write latency is 4
// Notes:   Activate and column words are checked off queues
`timescale 1ns/10ps
module tb_ddr2_dev;
   import ddr2_pkg::*;
   logic        clk_i, rstn_i, ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, self_refresh_i;
   logic        dqs_i, dq_oe_o, dqs_o, dqs_n_o, dqs_oe_o, act_valid_o, col_valid_o, col_ready_i;
   logic        termination_switch_a_o, termination_switch_b_o, termination_switch_c_o, dqs_m;
   logic        cmd_lost_o;
   logic [2:0]  ba_i, additive_latency_o, act_bank_o, b;
   logic [12:0] addr_i, act_row_o, r;
   logic [15:0] dq_i, dq_o, dq_m;
   logic [3:0]  pullup_step_o, pulldown_step_o, read_latency_o, write_latency_o;
   col_cmd_t    col_data_o;
   logic [18:0] act_q[$], col_q[$];
   logic [3:0]  codes[5] = '{4'h1, 4'h4, 4'h6, 4'ha, 4'h3};
   logic [7:0]  steps[5] = '{8'h98, 8'h99, 8'h8a, 8'h79, 8'h79};
   int          error_cnt, n_tests, seed, i, lost_cnt;
   assign dq_i = dq_oe_o ? dq_o : dq_m;
   assign dqs_i = dqs_oe_o ? dqs_o : dqs_m;
   ctrl_model m (.clk_i, .ck_o(ck_i), .pin_o({cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i}),
      .dat_o({dq_m, dqs_m}));
   ddr2_dev i_dut (.*);
   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      clk_i = 0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #50000;
      error_cnt++;
      conclude;
   end
   always @(posedge clk_i) begin
      if (act_valid_o === 1'b1) begin
         chk({3'h1, act_bank_o, act_row_o}, act_q.pop_front());
      end
      if (col_valid_o === 1'b1 && col_ready_i === 1'b1) begin
         chk({2'h0, col_data_o}, col_q.pop_front());
      end
      if (cmd_lost_o === 1'b1) begin
         lost_cnt++;
      end
   end
   initial begin
      {rstn_i, odt_i, self_refresh_i, col_ready_i} = 4'h1;
      {error_cnt, n_tests, seed} = {64'h0, 32'h608a111e};
      lost_cnt = 0;
      repeat (20) @(posedge clk_i);
      #1 rstn_i = 1;
      chk({pullup_step_o, pulldown_step_o, read_latency_o, write_latency_o, additive_latency_o},
         {4'h8, 4'h8, 4'h3, 4'h2, 3'h0});
      m.cmd(4'h0, BA_MR, 13'h032);
      m.cmd(4'h0, BA_EMR3, 13'h000);
      m.cmd(4'h0, BA_EMR1, 13'h010);
      repeat (4) @(posedge clk_i);
      chk({pullup_step_o, pulldown_step_o, read_latency_o, write_latency_o, additive_latency_o},
         {4'h8, 4'h8, 4'h5, 4'h4, 3'h2});
      for (i = 1; i < 3; i++) begin
         m.cmd(4'h0, BA_EMR1, 13'h010 | 13'(i << 7));
         repeat (4) @(posedge clk_i);
         chk({dq_o, dqs_o, dqs_n_o, dq_oe_o & dqs_oe_o},
            {{16{i == 1}}, i == 1, i == 2, 1'b1});
         m.cmd(4'h0, BA_EMR1, 13'h010);
      end
      @(posedge clk_i) #1 odt_i = 1;
      for (i = 1; i < 4; i++) begin
         m.cmd(4'h0, BA_EMR1, 13'h010 | 13'((i & 2) << 5) | 13'((i & 1) << 2));
         repeat (8) @(posedge clk_i);
         chk(19'({termination_switch_a_o, termination_switch_b_o, termination_switch_c_o,
            dq_oe_o | dqs_oe_o}), 19'({i == 1, i == 2, i == 3, 1'b0}));
      end
      #1 self_refresh_i = 1;
      repeat (8) @(posedge clk_i);
      chk(19'({termination_switch_a_o, termination_switch_b_o, termination_switch_c_o}),
         19'h0);
      #1 {self_refresh_i, col_ready_i} = 2'h0;
      for (i = 0; i < 2; i++) begin
         {b, r} = {3'(2 * i + 1), 13'($random(seed))};
         act_q.push_back({3'h1, b, r});
         col_q.push_back({2'h0, i[0], b, r});
         m.cmd(4'h3, b, r);
         m.cmd({3'h2, ~i[0]}, b, r);
      end
      repeat (40) @(posedge clk_i);
      chk(19'(col_valid_o), 19'h1);
      for (i = 0; i < 3; i++) begin
         r = 13'($random(seed));
         if (i < 2) begin
            col_q.push_back({3'h0, 3'h1, r});
         end
         m.cmd(4'h5, 3'h1, r);
      end
      m.cmd(4'h2, 3'h0, 13'h400);
      @(posedge clk_i) #1 col_ready_i = 1;
      for (i = 0; i < 5; i++) begin
         m.adj(codes[i], 4);
         chk(19'({pullup_step_o, pulldown_step_o}), 19'(steps[i]));
      end
      repeat (9) m.adj(4'h1, 4);
      chk(19'(pullup_step_o), 19'hf);
      m.cmd(4'h0, BA_EMR1, 13'h390);
      m.cmd(4'h0, BA_EMR1, 13'h010);
      chk(19'({pullup_step_o, pulldown_step_o}), 19'({STEP_DEFAULT, STEP_DEFAULT}));
      chk(19'(lost_cnt), 19'h1);
      chk(19'(act_q.size() + col_q.size()), 19'h0);
      conclude;
   end
endmodule
